/* File: design/adccal_coef_reg.sv */
// One 14-bit calibration coefficient held as a 6-bit high and 8-bit low register.
// Assumes one write strobe per half, same clock as the register side.
`timescale 1ns/1ps
module adccal_coef_reg
(
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        load,
  input  wire logic [adccal_pkg::COEF_W-1:0] load_val,
  input  wire logic                        wr_high,
  input  wire logic                        wr_low,
  input  wire logic [7:0]                  wdata,
  output logic      [adccal_pkg::COEF_W-1:0] coef
);

  logic [adccal_pkg::HIGH_W-1:0] high_r;
  logic [adccal_pkg::LOW_W-1:0]  low_r;

  // Factory load wins over software; software can recalibrate later
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      high_r <= adccal_pkg::COEF_RST[13:8];
      low_r  <= adccal_pkg::COEF_RST[7:0];
    end
    else if (load)
    begin
      high_r <= load_val[13:8];
      low_r  <= load_val[7:0];
    end
    else
    begin
      if (wr_high)
        high_r <= wdata[5:0];
      if (wr_low)
        low_r  <= wdata;
    end
  end

  // High half in bits 13..8, low half in 7..0
  assign coef = {high_r, low_r};

endmodule : adccal_coef_reg

/* File: design/adccal_pkg.sv */
// ADC calibration and DMA gating package: offsets, fields, reset values, types.
// Assumes an 8-bit special-function-register access from the processor core.
package adccal_pkg;

  // Special-function-register offsets (8-bit SFR space)
  localparam logic [7:0] ADDR_CONTROL_TWO = 8'hD8;
  localparam logic [7:0] ADDR_OFS_LOW     = 8'hF1;
  localparam logic [7:0] ADDR_OFS_HIGH    = 8'hF2;
  localparam logic [7:0] ADDR_GAIN_LOW    = 8'hF3;
  localparam logic [7:0] ADDR_GAIN_HIGH   = 8'hF4;

  // Field positions and widths
  localparam int COEF_W      = 14;
  localparam int HIGH_W      = 6;
  localparam int LOW_W       = 8;
  localparam int DMA_EN_BIT  = 6;
  localparam int DONE_BIT    = 7;

  // Reset values before the factory load completes
  localparam logic [7:0]        CONTROL_TWO_RST = 8'h00;
  localparam logic [COEF_W-1:0] COEF_RST        = 14'h2000;

  // Factory load length in clock cycles
  localparam int LOAD_CYCLES = 4;

  // Core external-port request
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] port0;
    logic [7:0] port2;
  } adccal_port_req_t;

  // Core SFR access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adccal_sfr_req_t;

  typedef enum logic [1:0] {
    ADCCAL_LOAD_IDLE,
    ADCCAL_LOAD_BUSY,
    ADCCAL_LOAD_DONE
  } adccal_load_t;

endpackage : adccal_pkg

/* File: design/adccal_port_gate.sv */
// Gates core accesses to the two external ports while DMA capture owns them.
// Assumes the DMA engine drives the ports itself; core timing is untouched.
`timescale 1ns/1ps
module adccal_port_gate
(
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         dma_active,
  input  wire adccal_pkg::adccal_port_req_t core_req,
  output adccal_pkg::adccal_port_req_t      port_out
);

  // Registered port drive; blocked requests produce no port activity
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      port_out <= '0;
    else if (dma_active)
      port_out <= '0;
    else
      port_out <= core_req;
  end

endmodule : adccal_port_gate

/* File: design/adccal_top.sv */
// ADC calibration coefficient registers, DMA port gating and completion flag.
// Assumes an SFR read/write strobe from the core and a DMA engine done pulse.
`timescale 1ns/1ps
module adccal_top
(
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire adccal_pkg::adccal_sfr_req_t  sfr_req,
  output logic      [7:0]                   sfr_rdata,
  input  wire logic [adccal_pkg::COEF_W-1:0] factory_offset,
  input  wire logic [adccal_pkg::COEF_W-1:0] factory_gain,
  input  wire adccal_pkg::adccal_port_req_t core_port_req,
  output adccal_pkg::adccal_port_req_t      core_port_out,
  input  wire logic                         dma_block_done,
  output logic                              dma_enable,
  output logic                              core_stall,
  output logic                              adc_irq,
  output logic      [adccal_pkg::COEF_W-1:0] offset_coef,
  output logic      [adccal_pkg::COEF_W-1:0] gain_coef,
  output logic                              load_busy
);

  adccal_pkg::adccal_load_t load_state_r;
  logic [2:0]               load_cnt_r;
  logic                     load_pulse;
  logic [7:0]               control_two_r;
  logic [7:0]               rdata_nxt;

  // Write strobe decode shared by all registers
  function automatic logic sfr_wr_hit(input adccal_pkg::adccal_sfr_req_t r,
                                      input logic [7:0] a);
    sfr_wr_hit = r.wr && (r.addr == a);
  endfunction : sfr_wr_hit

  // Power-up configuration sequence; runs once after each reset release
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      load_state_r <= adccal_pkg::ADCCAL_LOAD_IDLE;
      load_cnt_r   <= 3'h0;
    end
    else
    begin
      unique case (load_state_r)
        adccal_pkg::ADCCAL_LOAD_IDLE:
        begin
          load_state_r <= adccal_pkg::ADCCAL_LOAD_BUSY;
          load_cnt_r   <= 3'(adccal_pkg::LOAD_CYCLES - 1);
        end
        adccal_pkg::ADCCAL_LOAD_BUSY:
        begin
          if (load_cnt_r == 3'h0)
            load_state_r <= adccal_pkg::ADCCAL_LOAD_DONE;
          else
            load_cnt_r <= load_cnt_r - 3'h1;
        end
        adccal_pkg::ADCCAL_LOAD_DONE:
          load_state_r <= adccal_pkg::ADCCAL_LOAD_DONE;
      endcase
    end
  end

  // Copy happens on the last busy cycle, so late factory inputs settle first
  assign load_pulse = (load_state_r == adccal_pkg::ADCCAL_LOAD_BUSY) &&
                      (load_cnt_r == 3'h0);
  assign load_busy  = (load_state_r != adccal_pkg::ADCCAL_LOAD_DONE);

  // Offset coefficient; higher value means downward shift in the converter
  adccal_coef_reg u_offset
  (
    .clk      (clk),
    .nrst     (nrst),
    .load     (load_pulse),
    .load_val (factory_offset),
    .wr_high  (sfr_wr_hit(sfr_req, adccal_pkg::ADDR_OFS_HIGH)),
    .wr_low   (sfr_wr_hit(sfr_req, adccal_pkg::ADDR_OFS_LOW)),
    .wdata    (sfr_req.wdata),
    .coef     (offset_coef)
  );

  // Gain coefficient; higher value means steeper slope in the converter
  adccal_coef_reg u_gain
  (
    .clk      (clk),
    .nrst     (nrst),
    .load     (load_pulse),
    .load_val (factory_gain),
    .wr_high  (sfr_wr_hit(sfr_req, adccal_pkg::ADDR_GAIN_HIGH)),
    .wr_low   (sfr_wr_hit(sfr_req, adccal_pkg::ADDR_GAIN_LOW)),
    .wdata    (sfr_req.wdata),
    .coef     (gain_coef)
  );

  // Control two: DMA enable bit written by software, done flag set by hardware
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      control_two_r <= adccal_pkg::CONTROL_TWO_RST;
    else
    begin
      if (sfr_wr_hit(sfr_req, adccal_pkg::ADDR_CONTROL_TWO))
        control_two_r <= sfr_req.wdata;
      // Set wins over a same-cycle software clear
      if (dma_block_done)
        control_two_r[adccal_pkg::DONE_BIT] <= 1'b1;
    end
  end

  assign dma_enable = control_two_r[adccal_pkg::DMA_EN_BIT];
  assign adc_irq    = control_two_r[adccal_pkg::DONE_BIT];
  // Never stall the core; DMA only steals the ports
  assign core_stall = 1'b0;

  // Port gating while DMA is enabled
  adccal_port_gate u_gate
  (
    .clk        (clk),
    .nrst       (nrst),
    .dma_active (dma_enable),
    .core_req   (core_port_req),
    .port_out   (core_port_out)
  );

  // Read mux; unmapped addresses read zero, upper coefficient bits zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    unique case (sfr_req.addr)
      adccal_pkg::ADDR_CONTROL_TWO: rdata_nxt = control_two_r;
      adccal_pkg::ADDR_OFS_HIGH:    rdata_nxt = {2'h0, offset_coef[13:8]};
      adccal_pkg::ADDR_OFS_LOW:     rdata_nxt = offset_coef[7:0];
      adccal_pkg::ADDR_GAIN_HIGH:   rdata_nxt = {2'h0, gain_coef[13:8]};
      adccal_pkg::ADDR_GAIN_LOW:    rdata_nxt = gain_coef[7:0];
      default:                      rdata_nxt = 8'h00;
    endcase
  end

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sfr_rdata <= 8'h00;
    else if (sfr_req.rd)
      sfr_rdata <= rdata_nxt;
  end

endmodule : adccal_top

/* File: test/adc_calibration_and_dma_gating_tb.sv */
// Testbench: registers, factory load, port gating and done flag.
// Assumes the core model owns the SFR strobes; factory values are fixed.
`timescale 1ns/1ps
module adc_calibration_and_dma_gating_tb;
  localparam logic [13:0] FOFS  = 14'h1ABC;
  localparam logic [13:0] FGAIN = 14'h0123;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic dma_block_done = 1'b0;
  logic dma_enable, core_stall, adc_irq, load_busy;
  logic [13:0] offset_coef, gain_coef;
  logic [7:0]  rdata, rd_v;
  adccal_pkg::adccal_sfr_req_t  sfr_req;
  adccal_pkg::adccal_port_req_t preq = '0;
  adccal_pkg::adccal_port_req_t pout;
  int miscompares = 0;
  int samples_checked = 0;
  // Rows: address, written byte, byte read back; E0 is unmapped
  logic [23:0] rows [6] = '{24'hF1A5A5, 24'hF22A2A, 24'hF35C5C, 24'hF41515,
                            24'hD84040, 24'hE07700};

  always #2 clk = ~clk;

  adccal_core_model i_core(.clk, .sfr_rdata(rdata), .sfr_req);
  adccal_top i_dut(.clk, .nrst, .sfr_req, .sfr_rdata(rdata), .factory_offset(FOFS),
    .factory_gain(FGAIN), .core_port_req(preq), .core_port_out(pout), .dma_block_done,
    .dma_enable, .core_stall, .adc_irq, .offset_coef, .gain_coef, .load_busy);

  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Main sequence; waits are bounded so a hang ends in the report
  initial
  begin
    repeat (12) @(posedge clk);
    chk("reset coef", 18'h2000, {4'h0, offset_coef});
    nrst <= 1'b1;
    for (int i = 0; i < 20 && load_busy !== 1'b0; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (load_busy !== 1'b0)
    begin
      miscompares++;
      tally_and_finish();
    end
    chk("factory ofs", {4'h0, FOFS}, {4'h0, offset_coef});
    chk("factory gain", {4'h0, FGAIN}, {4'h0, gain_coef});
    $display("test reset done");
    foreach (rows[i])
    begin
      i_core.wr(rows[i][23:16], rows[i][15:8]);
      i_core.rd(rows[i][23:16], rd_v);
      chk("sfr read", {10'h0, rows[i][7:0]}, {10'h0, rd_v});
    end
    chk("ofs coef", 18'h2AA5, {4'h0, offset_coef});
    chk("gain coef", 18'h155C, {4'h0, gain_coef});
    chk("dma on", 18'h1, {17'h0, dma_enable});
    $display("test registers done");
    @(posedge clk);
    preq <= '{1'b1, 1'b1, 8'h5A, 8'h3C};
    @(posedge clk);
    #1;
    chk("gated port", 18'h0, pout);
    chk("no stall", 18'h0, {17'h0, core_stall});
    i_core.wr(8'hD8, 8'h00);
    @(posedge clk);
    #1;
    chk("open port", preq, pout);
    $display("test gating done");
    @(posedge clk);
    dma_block_done <= 1'b1;
    @(posedge clk);
    dma_block_done <= 1'b0;
    #1;
    chk("done flag", 18'h1, {17'h0, adc_irq});
    i_core.rd(8'hD8, rd_v);
    chk("flag bit", 18'h80, {10'h0, rd_v});
    i_core.wr(8'hD8, 8'h00);
    #1;
    chk("flag clear", 18'h0, {17'h0, adc_irq});
    $display("test done flag done");
    tally_and_finish();
  end
endmodule : adc_calibration_and_dma_gating_tb

/* File: test/adccal_checker.sv */
// Checker: port-level timing of the ADC calibration block.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
module adccal_checker
(
  input wire logic                        clk,
  input wire logic                        nrst,
  input wire adccal_pkg::adccal_sfr_req_t  sfr_req,
  input wire adccal_pkg::adccal_port_req_t core_port_req,
  input wire adccal_pkg::adccal_port_req_t core_port_out,
  input wire logic                        dma_block_done,
  input wire logic                        dma_enable,
  input wire logic                        core_stall,
  input wire logic                        adc_irq,
  input wire logic [13:0]                 offset_coef,
  input wire logic [13:0]                 gain_coef,
  input wire logic                        load_busy,
  input wire logic [13:0]                 factory_offset,
  input wire logic [13:0]                 factory_gain
);
  // All checks share one clock and reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  stall_never_a: assert property (core_stall == 1'b0)
    else $error("core stalled");
  gate_off_a: assert property (dma_enable |=> core_port_out == '0)
    else $error("port access leaked during capture");
  gate_pass_a: assert property (!dma_enable |=> core_port_out == $past(core_port_req))
    else $error("port access lost outside capture");
  done_sets_a: assert property (dma_block_done |=> adc_irq)
    else $error("done pulse gave no flag");
  flag_hold_a: assert property (adc_irq && !(sfr_req.wr &&
    sfr_req.addr == adccal_pkg::ADDR_CONTROL_TWO) |=> adc_irq)
    else $error("done flag dropped by itself");
  ofs_high_a: assert property (sfr_req.wr &&
    sfr_req.addr == adccal_pkg::ADDR_OFS_HIGH && !load_busy
    |=> offset_coef[13:8] == $past(sfr_req.wdata[5:0])) else $error("offset high wrong");
  gain_low_a: assert property (sfr_req.wr &&
    sfr_req.addr == adccal_pkg::ADDR_GAIN_LOW && !load_busy
    |=> gain_coef[7:0] == $past(sfr_req.wdata)) else $error("gain low wrong");
  load_copy_a: assert property ($fell(load_busy)
    |-> offset_coef == factory_offset && gain_coef == factory_gain)
    else $error("factory copy wrong");
endmodule : adccal_checker

bind adccal_top adccal_checker i_chk(.clk, .nrst, .sfr_req, .core_port_req, .core_port_out,
  .dma_block_done, .dma_enable, .core_stall, .adc_irq, .offset_coef, .gain_coef, .load_busy,
  .factory_offset, .factory_gain);

/* File: test/adccal_core_model.sv */
// Processor core model: issues SFR writes and reads.
// Assumes strobes are taken at the rising edge, read data a cycle later.
`timescale 1ns/1ps
module adccal_core_model
(
  input  wire logic                    clk,
  input  wire logic [7:0]              sfr_rdata,
  output adccal_pkg::adccal_sfr_req_t  sfr_req
);
  initial sfr_req = '0;
  // Strobe held one cycle, dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_req <= '{1'b0, 1'b1, a, d};
    @(posedge clk);
    sfr_req <= '0;
  endtask : wr
  // Data is picked up once the taking edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_req <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk);
    sfr_req <= '0;
    #1;
    d = sfr_rdata;
  endtask : rd
endmodule : adccal_core_model
